// File: rtl/eca_pkg.sv
// Package of constants and types for the eight-bit core ALU datapath
`default_nettype none
package eca_pkg;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 12;
    localparam int PTR_W = 9;
    localparam int ADDR_W = 5;
    localparam int PHASES = 4;
    // Instruction cycle: 200 device clocks at 200 MHz gives 1 us
    localparam int CYCLE_NS = 1000;
    localparam int CLK_NS = 5;
    localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;
    localparam int PHASE_CLKS = CYCLE_CLKS / PHASES;
    localparam logic [7:0] PHASE_CNT_MAX = 8'(PHASE_CLKS - 1);
    // Data-memory address of the instruction pointer low byte
    localparam logic [ADDR_W-1:0] PTR_ADDR = 5'h02;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 5'h03;
    // Flag numbering; the status byte itself holds carry at bit 2 and zero at bit 0
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_NIBBLE = 1;
    localparam int FLAG_ZERO = 2;
    localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
    localparam logic [PTR_W-1:0] PTR_RST = 9'h1FF;
    localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;
    // Instruction field layout
    localparam int OP_HI = 11;
    localparam int OP_LO = 8;
    localparam int DEST_BIT = 5;

    typedef enum logic [3:0] {
        ECA_OP_NOP, ECA_OP_ADD, ECA_OP_SUB, ECA_OP_AND, ECA_OP_OR, ECA_OP_XOR,
        ECA_OP_MOV, ECA_OP_COM, ECA_OP_INC, ECA_OP_DEC, ECA_OP_RL, ECA_OP_RR,
        ECA_OP_SWAP, ECA_OP_GOTO, ECA_OP_LIT_AND, ECA_OP_LIT_MOV
    } eca_op_t;

    typedef enum logic [1:0] {ECA_PH_ONE, ECA_PH_TWO, ECA_PH_THREE, ECA_PH_FOUR} eca_phase_t;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } eca_data_req_t;

    typedef struct packed {
        logic carry;
        logic nibble;
        logic zero;
    } eca_flags_t;
endpackage
`default_nettype wire

// File: rtl/eca_op_latch.sv
// Fetched opcode latch with registered read-out and flush to no-operation
`default_nettype none
module eca_op_latch (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic flush,
    input wire logic [eca_pkg::INSTR_W-1:0] word_in,
    output logic [eca_pkg::INSTR_W-1:0] word_out
);
    // A flush on load replaces the prefetched word with a no-operation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word_out <= eca_pkg::NOP_WORD;
        end else if (load) begin
            word_out <= flush ? eca_pkg::NOP_WORD : word_in;
        end
    end
endmodule
`default_nettype wire

// File: rtl/eca_core.sv
// Execution core: phase divider, two-stage pipeline and 8-bit ALU
`default_nettype none
module eca_core (
    input wire logic clk,
    input wire logic sys_rst,
    output logic [eca_pkg::PTR_W-1:0] prog_addr,
    input wire logic [eca_pkg::INSTR_W-1:0] prog_data,
    output eca_pkg::eca_data_req_t data_req,
    output logic data_rd,
    input wire logic [eca_pkg::DATA_W-1:0] data_rdata,
    output logic [eca_pkg::DATA_W-1:0] acc_out,
    output eca_pkg::eca_flags_t flags_out,
    output logic [1:0] phase_out
);
    ////////////////////////////////////////////////////////////////////////
    // Phase divider
    logic [7:0] sub_cnt;
    eca_pkg::eca_phase_t phase;
    wire phase_end = (sub_cnt == eca_pkg::PHASE_CNT_MAX);
    wire ph1_go = phase_end && (phase == eca_pkg::ECA_PH_FOUR);
    wire ph2_go = phase_end && (phase == eca_pkg::ECA_PH_ONE);
    wire ph4_go = phase_end && (phase == eca_pkg::ECA_PH_THREE);

    // Four phases per cycle, each an equal share of the 1 us cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sub_cnt <= 8'h00;
            phase <= eca_pkg::ECA_PH_ONE;
        end else if (phase_end) begin
            sub_cnt <= 8'h00;
            case (phase)
                eca_pkg::ECA_PH_ONE: phase <= eca_pkg::ECA_PH_TWO;
                eca_pkg::ECA_PH_TWO: phase <= eca_pkg::ECA_PH_THREE;
                eca_pkg::ECA_PH_THREE: phase <= eca_pkg::ECA_PH_FOUR;
                default: phase <= eca_pkg::ECA_PH_ONE;
            endcase
        end else begin
            sub_cnt <= sub_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode of the word held in the opcode latch
    logic [eca_pkg::INSTR_W-1:0] opcode;
    logic flush_next;
    wire [3:0] op_field = opcode[eca_pkg::OP_HI:eca_pkg::OP_LO];
    wire eca_pkg::eca_op_t op = eca_pkg::eca_op_t'(op_field);
    wire to_reg = opcode[eca_pkg::DEST_BIT];
    wire [eca_pkg::ADDR_W-1:0] reg_addr = opcode[eca_pkg::ADDR_W-1:0];
    wire [eca_pkg::DATA_W-1:0] imm = opcode[7:0];
    wire is_imm = (op == eca_pkg::ECA_OP_LIT_AND) || (op == eca_pkg::ECA_OP_LIT_MOV);
    wire is_branch = (op == eca_pkg::ECA_OP_GOTO);
    wire writes_ptr = to_reg && !is_imm && !is_branch && (op != eca_pkg::ECA_OP_NOP)
                      && (reg_addr == eca_pkg::PTR_ADDR);
    wire ptr_change = is_branch || writes_ptr;

    // Opcode latch, loaded at the cycle boundary; flush kills the prefetch
    eca_op_latch u_latch (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(ph1_go),
        .flush(flush_next),
        .word_in(prog_data),
        .word_out(opcode)
    );

    ////////////////////////////////////////////////////////////////////////
    // ALU
    logic [eca_pkg::DATA_W-1:0] acc;
    logic [eca_pkg::DATA_W-1:0] operand;
    eca_pkg::eca_flags_t flags;

    // Add with carry and nibble carry; subtraction adds the complement plus one
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        return {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction

    wire [eca_pkg::DATA_W-1:0] src_b = is_imm ? imm : operand;
    wire [9:0] sum_add = add8(src_b, acc, 1'b0);
    wire [9:0] sum_sub = add8(src_b, ~acc, 1'b1);
    logic [eca_pkg::DATA_W-1:0] alu_res;
    logic next_carry;
    logic upd_c;
    logic upd_dc;
    logic upd_z;

    // Result selection; carry 1 in subtraction means no borrow
    always_comb begin
        alu_res = operand;
        next_carry = flags.carry;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        upd_z = 1'b0;
        case (op)
            eca_pkg::ECA_OP_ADD: begin
                alu_res = sum_add[7:0];
                next_carry = sum_add[9];
                {upd_c, upd_dc, upd_z} = 3'h7;
            end
            eca_pkg::ECA_OP_SUB: begin
                alu_res = sum_sub[7:0];
                next_carry = sum_sub[9];
                {upd_c, upd_dc, upd_z} = 3'h7;
            end
            eca_pkg::ECA_OP_AND: begin alu_res = acc & operand; upd_z = 1'b1; end
            eca_pkg::ECA_OP_OR: begin alu_res = acc | operand; upd_z = 1'b1; end
            eca_pkg::ECA_OP_XOR: begin alu_res = acc ^ operand; upd_z = 1'b1; end
            eca_pkg::ECA_OP_MOV: begin alu_res = operand; upd_z = 1'b1; end
            eca_pkg::ECA_OP_COM: begin alu_res = ~operand; upd_z = 1'b1; end
            eca_pkg::ECA_OP_INC: begin alu_res = operand + 8'h01; upd_z = 1'b1; end
            eca_pkg::ECA_OP_DEC: begin alu_res = operand - 8'h01; upd_z = 1'b1; end
            eca_pkg::ECA_OP_RL: begin
                alu_res = {operand[6:0], flags.carry};
                next_carry = operand[7];
                upd_c = 1'b1;
            end
            eca_pkg::ECA_OP_RR: begin
                alu_res = {flags.carry, operand[7:1]};
                next_carry = operand[0];
                upd_c = 1'b1;
            end
            eca_pkg::ECA_OP_SWAP: alu_res = {operand[3:0], operand[7:4]};
            eca_pkg::ECA_OP_LIT_AND: begin alu_res = acc & imm; upd_z = 1'b1; end
            eca_pkg::ECA_OP_LIT_MOV: alu_res = imm;
            default: alu_res = operand;
        endcase
    end

    wire alu_op = (op != eca_pkg::ECA_OP_NOP) && !is_branch;
    wire dest_reg = alu_op && to_reg && !is_imm; // Accumulator has no address
    wire [eca_pkg::PTR_W-1:0] branch_target = opcode[eca_pkg::PTR_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Instruction pointer and fetch; runs in parallel with data access
    // A pointer change in execution costs one flushed cycle so the stale
    // prefetch never executes, trading one cycle for a simple pipeline.
    // Both redirects store the target minus one: the phase-one increment
    // then lands on the target, so the flushed slot is the only cycle lost.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prog_addr <= eca_pkg::PTR_RST;
            flush_next <= 1'b0;
        end else if (ph1_go) begin
            prog_addr <= prog_addr + 9'h001;
            flush_next <= 1'b0;
        end else if (ph4_go && ptr_change) begin
            prog_addr <= (is_branch ? branch_target : {1'b0, alu_res}) - 9'h001;
            flush_next <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data bus: read in phase two, write in phase four
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_req <= '0;
            data_rd <= 1'b0;
            operand <= 8'h00;
        end else begin
            data_rd <= ph2_go && alu_op && !is_imm;
            data_req.we <= ph4_go && dest_reg && !writes_ptr;
            data_req.addr <= reg_addr;
            data_req.wdata <= alu_res;
            if (data_rd) begin
                operand <= (reg_addr == eca_pkg::STATUS_ADDR) ? {5'h00, flags} : data_rdata;
            end
        end
    end

    // Accumulator and flags commit in phase four
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc <= 8'h00;
            flags <= '0;
        end else if (ph4_go && alu_op) begin
            if (!dest_reg) acc <= alu_res;
            if (upd_c) flags.carry <= next_carry;
            if (upd_dc) flags.nibble <= is_imm ? 1'b0 : (op == eca_pkg::ECA_OP_SUB ? sum_sub[8] : sum_add[8]);
            if (upd_z) flags.zero <= (alu_res == 8'h00);
        end
    end

    // Registered copies for observation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_out <= 8'h00;
            flags_out <= '0;
            phase_out <= 2'h0;
        end else begin
            acc_out <= acc;
            flags_out <= flags;
            phase_out <= phase;
        end
    end
endmodule
`default_nettype wire

// File: tb/eca_core_checker.sv
// Port timing checks for the execution core
`default_nettype none
module eca_core_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [eca_pkg::PTR_W-1:0] prog_addr,
    input wire logic [eca_pkg::INSTR_W-1:0] prog_data,
    input wire eca_pkg::eca_data_req_t data_req,
    input wire logic data_rd,
    input wire logic [eca_pkg::DATA_W-1:0] data_rdata,
    input wire logic [eca_pkg::DATA_W-1:0] acc_out,
    input wire eca_pkg::eca_flags_t flags_out,
    input wire logic [1:0] phase_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [1:0] ph_q;
    logic [7:0] pcnt;
    logic seen;
    wire logic ph_chg = phase_out != ph_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Clocks in the current phase; the first phase after reset is left untimed
    always_ff @(posedge clk) begin
        ph_q <= phase_out;
        pcnt <= (sys_rst || ph_chg) ? 8'h00 : pcnt + 8'h01;
        seen <= !sys_rst && (seen || ph_chg);
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_phase_step; !$stable(phase_out) |-> phase_out == 2'($past(phase_out) + 2'h1); endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase skipped");
    property p_phase_len; ph_chg && seen |-> pcnt == eca_pkg::PHASE_CNT_MAX; endproperty
    a_phase_len: assert property (p_phase_len) else $error("phase ended early");
    property p_phase_max; seen |-> pcnt <= eca_pkg::PHASE_CNT_MAX; endproperty
    a_phase_max: assert property (p_phase_max) else $error("phase overran");
    // The phase copy lags one clock: an increment is followed by phase one, a redirect by phase four
    property p_addr_when; $changed(prog_addr) |=> ph_chg && (phase_out == 2'h0 || phase_out == 2'h3); endproperty
    a_addr_when: assert property (p_addr_when) else $error("fetch address moved mid cycle");
    property p_rd_phase; data_rd |=> phase_out == 2'h1; endproperty
    a_rd_phase: assert property (p_rd_phase) else $error("read outside phase two");
    property p_rd_pulse; data_rd |=> !data_rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    property p_we_phase; data_req.we |=> phase_out == 2'h3; endproperty
    a_we_phase: assert property (p_we_phase) else $error("write outside phase four");
    property p_we_pulse; data_req.we |=> !data_req.we; endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
endmodule
bind eca_core eca_core_checker u_chk (.clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_req(data_req), .data_rd(data_rd), .data_rdata(data_rdata), .acc_out(acc_out), .flags_out(flags_out),
    .phase_out(phase_out));
`default_nettype wire

// File: tb/eca_mem_model.sv
// Program memory and data register file facing the core
`default_nettype none
module eca_mem_model (
    input wire logic clk,
    input wire logic [eca_pkg::PTR_W-1:0] prog_addr,
    output logic [eca_pkg::INSTR_W-1:0] prog_data,
    input wire eca_pkg::eca_data_req_t data_req,
    input wire logic data_rd,
    output logic [eca_pkg::DATA_W-1:0] data_rdata
);
    logic [eca_pkg::INSTR_W-1:0] prog [512];
    logic [eca_pkg::DATA_W-1:0] regs [32];
    // Whole word per fetch on a bus of its own
    assign prog_data = prog[prog_addr];
    // The core takes read data in the clock its strobe stands; inverted otherwise so a late sample cannot pass
    assign data_rdata = data_rd ? regs[data_req.addr] : ~regs[data_req.addr];
    // Take writes
    always @(posedge clk) begin
        if (data_req.we) begin
            regs[data_req.addr] <= data_req.wdata;
        end
    end
endmodule
`default_nettype wire

// File: tb/test_eight_bit_core_alu_datapath.sv
// Self-checking bench for the execution core
`default_nettype none
module test_eight_bit_core_alu_datapath;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [eca_pkg::PTR_W-1:0] prog_addr;
    logic [eca_pkg::INSTR_W-1:0] prog_data;
    eca_pkg::eca_data_req_t data_req;
    logic data_rd;
    logic [eca_pkg::DATA_W-1:0] data_rdata;
    logic [eca_pkg::DATA_W-1:0] acc_out;
    eca_pkg::eca_flags_t flags_out;
    logic [1:0] phase_out;
    int bad_count = 0;
    int n_checks = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Device clock and the two parties
    always #2.5 clk = ~clk;
    eca_core DUT (.clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .prog_data(prog_data), .data_req(data_req),
        .data_rd(data_rd), .data_rdata(data_rdata), .acc_out(acc_out), .flags_out(flags_out), .phase_out(phase_out));
    eca_mem_model MDL (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data), .data_req(data_req),
        .data_rd(data_rd), .data_rdata(data_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    // Comparisons
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flags(input eca_pkg::eca_flags_t exp, input eca_pkg::eca_flags_t got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR flags expected %h seen %h", exp, got);
        end
    endtask
    // Blank memories and hold reset ten clocks; program is loaded meanwhile
    task automatic prep();
        @(posedge clk);
        #1 sys_rst = 1'b1;
        for (int i = 0; i < 512; i++) MDL.prog[i] = eca_pkg::NOP_WORD;
        for (int i = 0; i < 32; i++) MDL.regs[i] = 8'h00;
        repeat (10) @(posedge clk);
    endtask
    // Eight-cycle run; the six-instruction test's last result lands in the final cycle
    task automatic go();
        #1 sys_rst = 1'b0;
        repeat (8 * eca_pkg::CYCLE_CLKS) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios: immediate load, then register operation
    task automatic t_add();
        prep();
        MDL.prog[0] = 12'hF0F;
        MDL.prog[1] = 12'h110;
        MDL.regs[16] = 8'h01;
        go();
        chk_byte("acc", 8'h10, acc_out);
        chk_flags(3'h2, flags_out);
        chk_byte("reg16", 8'h01, MDL.regs[16]);
        $display("add test done");
    endtask
    task automatic t_sub();
        prep();
        MDL.prog[0] = 12'hF14;
        MDL.prog[1] = 12'h231;
        MDL.regs[17] = 8'h03;
        go();
        chk_byte("reg17", 8'hEF, MDL.regs[17]);
        chk_flags(3'h0, flags_out);
        chk_byte("acc", 8'h14, acc_out);
        $display("borrow test done");
    endtask
    task automatic t_zero();
        prep();
        MDL.prog[0] = 12'hF33;
        MDL.prog[1] = 12'h212;
        MDL.regs[18] = 8'h33;
        go();
        chk_byte("acc", 8'h00, acc_out);
        chk_flags(3'h7, flags_out);
        $display("zero test done");
    endtask
    // Prefetched load after a jump must never take effect
    task automatic t_branch();
        prep();
        MDL.prog[0] = 12'hD05;
        MDL.prog[1] = 12'hFAA;
        MDL.prog[261] = 12'h110;
        MDL.regs[16] = 8'h01;
        go();
        chk_byte("acc", 8'h01, acc_out);
        chk_flags(3'h0, flags_out);
        $display("branch test done");
    endtask
    // Move into the pointer address redirects fetch; the register is not written
    task automatic t_ptr();
        prep();
        MDL.prog[0] = 12'h622;
        MDL.prog[1] = 12'hFAA;
        MDL.prog[64] = 12'hF5A;
        MDL.regs[2] = 8'h40;
        go();
        chk_byte("acc", 8'h5A, acc_out);
        chk_byte("reg2", 8'h40, MDL.regs[2]);
        chk_flags(3'h0, flags_out);
        $display("pointer write test done");
    endtask
    // Logic, immediate and rotate operations in one run, carry passed through rotates
    task automatic t_logic();
        prep();
        MDL.prog[0] = 12'hF5A;
        MDL.prog[1] = 12'h530;
        MDL.prog[2] = 12'hE0F;
        MDL.prog[3] = 12'hA31;
        MDL.prog[4] = 12'hB12;
        MDL.prog[5] = 12'h313;
        MDL.regs[16] = 8'hFF;
        MDL.regs[17] = 8'h81;
        MDL.regs[18] = 8'h04;
        MDL.regs[19] = 8'h01;
        go();
        chk_byte("reg16", 8'hA5, MDL.regs[16]);
        chk_byte("reg17", 8'h02, MDL.regs[17]);
        chk_byte("reg19", 8'h01, MDL.regs[19]);
        chk_byte("acc", 8'h00, acc_out);
        chk_flags(3'h1, flags_out);
        $display("logic test done");
    endtask
    // Verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        t_add();
        t_sub();
        t_zero();
        t_branch();
        t_ptr();
        t_logic();
        summarize();
    end
endmodule
`default_nettype wire
